// ===== design/calc_pkg.sv
// Constants for the user variable calculation unit.
// Assumes one 125 MHz clock and byte-wide frame links with valid/ready.
// Functional notes
// - Opcode 41: var op accu, into var
// - Opcode 42: accu op var, into accu
// - Opcode 43: var op X, into var
// - Bank byte indexes var; value ignored
// - Types 0-4: add, sub, mul, div, mod
// - Types 5-7: and, or, xor
// - Type 8: inverted source into destination
// - Type 9: copy source into destination
// - Type 10: swap var and register
// - Type 11: compare, operands untouched
// - Link reply status 100 on success
// - Reply byte order fixed, value MSB first
package calc_pkg;
  localparam logic [7:0] OP_VAR_ACC = 8'h29;
  localparam logic [7:0] OP_ACC_VAR = 8'h2a;
  localparam logic [7:0] OP_VAR_X = 8'h2b;
  localparam logic [7:0] T_ADD = 8'h00;
  localparam logic [7:0] T_SUB = 8'h01;
  localparam logic [7:0] T_MUL = 8'h02;
  localparam logic [7:0] T_DIV = 8'h03;
  localparam logic [7:0] T_MODULO_OPERATION = 8'h04;
  localparam logic [7:0] T_AND = 8'h05;
  localparam logic [7:0] T_OR = 8'h06;
  localparam logic [7:0] T_XOR = 8'h07;
  localparam logic [7:0] T_NOT = 8'h08;
  localparam logic [7:0] T_LOAD = 8'h09;
  localparam logic [7:0] T_SWAP = 8'h0a;
  localparam logic [7:0] T_COMP = 8'h0b;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_OP = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] DEV_ADDR = 8'h01;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [3:0] B_INSTR = 4'h1;
  localparam logic [3:0] B_TYPE = 4'h2;
  localparam logic [3:0] B_BANK = 4'h3;
  localparam logic [3:0] B_LAST = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_EXEC = 2'b10,
    ST_SEND = 2'b11
  } state_e;
endpackage

// ===== design/user_var_alu.sv
// Calculation unit combining 256 user variables with accumulator and X register.
// Assumes synchronous byte links and a command port from a program sequencer.
module user_var_alu (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [7:0] RX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [7:0] CMD_TYPE,
  input wire logic [7:0] CMD_INDEX,
  output logic CMD_DONE,
  output logic [7:0] CMD_STATUS,
  input wire logic ACC_LOAD,
  input wire logic [31:0] ACC_LOAD_DATA,
  input wire logic X_LOAD,
  input wire logic [31:0] X_LOAD_DATA,
  input wire logic [7:0] VAR_RD_INDEX,
  output logic [31:0] VAR_RD_DATA,
  output logic [31:0] ACCU,
  output logic [31:0] XREG,
  output logic FLAG_ZERO,
  output logic FLAG_NEG,
  output logic FLAG_CARRY
);
  typedef struct packed {
    calc_pkg::state_e st;
    logic from_link;
    logic [3:0] cnt;
    logic [7:0] tgt;
    logic [7:0] op;
    logic [7:0] typ;
    logic [7:0] idx;
    logic [7:0] sum;
    logic [31:0] acc;
    logic [31:0] xr;
    logic [255:0][31:0] vars;
    logic zf;
    logic nf;
    logic cf;
    logic [8:0][7:0] tx_buf;
    logic [7:0] tx_byte;
    logic done;
    logic [7:0] status;
    logic [31:0] rd_data;
  } state_s;

  state_s q;
  state_s n;
  logic [31:0] var_v;
  logic [31:0] reg_v;
  logic [31:0] dst;
  logic [31:0] src;
  logic [31:0] res;
  logic [7:0] stat;
  logic [7:0] chk;
  logic op_ok;
  logic typ_ok;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    var_v = q.vars[q.idx];
    reg_v = (q.op == calc_pkg::OP_VAR_X) ? q.xr : q.acc;
    dst = var_v;
    src = reg_v;
    res = var_v;
    stat = calc_pkg::STATUS_OK;
    chk = 8'h00;
    op_ok = (q.op == calc_pkg::OP_VAR_ACC) || (q.op == calc_pkg::OP_ACC_VAR)
            || (q.op == calc_pkg::OP_VAR_X);
    typ_ok = (q.typ <= calc_pkg::T_COMP);
    // Outside loads land first so a command in the same cycle wins
    if (ACC_LOAD)
    begin
      n.acc = ACC_LOAD_DATA;
    end
    if (X_LOAD)
    begin
      n.xr = X_LOAD_DATA;
    end
    case (q.st)
      calc_pkg::ST_IDLE:
      begin
        if (CMD_VALID)
        begin
          n.op = CMD_OPCODE;
          n.typ = CMD_TYPE;
          n.idx = CMD_INDEX;
          n.from_link = 1'b0;
          n.st = calc_pkg::ST_EXEC;
        end
        else if (RX_VALID)
        begin
          n.tgt = RX_DATA;
          n.sum = RX_DATA;
          n.cnt = calc_pkg::CNT_ONE;
          n.st = calc_pkg::ST_RECV;
        end
      end
      calc_pkg::ST_RECV:
      begin
        if (RX_VALID)
        begin
          n.cnt = q.cnt + calc_pkg::CNT_ONE;
          n.sum = q.sum + RX_DATA;
          if (q.cnt == calc_pkg::B_INSTR)
          begin
            n.op = RX_DATA;
          end
          if (q.cnt == calc_pkg::B_TYPE)
          begin
            n.typ = RX_DATA;
          end
          if (q.cnt == calc_pkg::B_BANK)
          begin
            n.idx = RX_DATA;
          end
          // Value bytes 4..7 are counted into the sum only, never stored
          if (q.cnt == calc_pkg::B_LAST)
          begin
            n.cnt = 4'h0;
            n.from_link = 1'b1;
            // Foreign or corrupt frames vanish without a reply
            if (RX_DATA == q.sum && q.tgt == calc_pkg::DEV_ADDR)
            begin
              n.st = calc_pkg::ST_EXEC;
            end
            else
            begin
              n.st = calc_pkg::ST_IDLE;
            end
          end
        end
      end
      calc_pkg::ST_EXEC:
      begin
        if (q.op == calc_pkg::OP_ACC_VAR)
        begin
          dst = q.acc;
          src = var_v;
        end
        case (q.typ)
          calc_pkg::T_ADD: res = dst + src;
          calc_pkg::T_SUB: res = dst - src;
          calc_pkg::T_MUL: res = dst * src;
          // A zero divisor leaves the destination as it was
          calc_pkg::T_DIV: res = (src == calc_pkg::ZERO32) ? dst
                                 : 32'($signed(dst) / $signed(src));
          calc_pkg::T_MODULO_OPERATION: res = (src == calc_pkg::ZERO32) ? dst
                                 : 32'($signed(dst) % $signed(src));
          calc_pkg::T_AND: res = dst & src;
          calc_pkg::T_OR: res = dst | src;
          calc_pkg::T_XOR: res = dst ^ src;
          calc_pkg::T_NOT: res = ~src;
          calc_pkg::T_LOAD: res = src;
          calc_pkg::T_SWAP: res = src;
          default: res = dst;
        endcase
        if (!op_ok)
        begin
          stat = calc_pkg::STATUS_BAD_OP;
        end
        else if (!typ_ok)
        begin
          stat = calc_pkg::STATUS_BAD_TYPE;
        end
        else if (q.typ == calc_pkg::T_COMP)
        begin
          n.zf = (dst == src);
          n.nf = ($signed(dst) < $signed(src));
          n.cf = (dst < src);
        end
        else
        begin
          if (q.op == calc_pkg::OP_ACC_VAR)
          begin
            n.acc = res;
          end
          else
          begin
            n.vars[q.idx] = res;
          end
          if (q.typ == calc_pkg::T_SWAP)
          begin
            if (q.op == calc_pkg::OP_ACC_VAR)
            begin
              n.vars[q.idx] = dst;
            end
            else if (q.op == calc_pkg::OP_VAR_X)
            begin
              n.xr = dst;
            end
            else
            begin
              n.acc = dst;
            end
          end
        end
        chk = calc_pkg::HOST_ADDR + calc_pkg::DEV_ADDR + stat + q.op
              + res[31:24] + res[23:16] + res[15:8] + res[7:0];
        n.tx_buf = {chk, res[7:0], res[15:8], res[23:16], res[31:24],
                    q.op, stat, calc_pkg::DEV_ADDR, calc_pkg::HOST_ADDR};
        n.tx_byte = calc_pkg::HOST_ADDR;
        n.status = stat;
        n.cnt = 4'h0;
        n.done = !q.from_link;
        n.st = q.from_link ? calc_pkg::ST_SEND : calc_pkg::ST_IDLE;
      end
      default:
      begin
        if (TX_READY)
        begin
          if (q.cnt == calc_pkg::B_LAST)
          begin
            n.cnt = 4'h0;
            n.st = calc_pkg::ST_IDLE;
          end
          else
          begin
            n.cnt = q.cnt + calc_pkg::CNT_ONE;
            n.tx_byte = q.tx_buf[q.cnt + calc_pkg::CNT_ONE];
          end
        end
      end
    endcase
    n.rd_data = q.vars[VAR_RD_INDEX];
  end

  // Variable store resets to zero; large, but keeps every read defined
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign CMD_READY = (q.st == calc_pkg::ST_IDLE);
  assign RX_READY = ((q.st == calc_pkg::ST_IDLE) && !CMD_VALID)
                    || (q.st == calc_pkg::ST_RECV);
  assign TX_VALID = (q.st == calc_pkg::ST_SEND);
  assign TX_DATA = q.tx_byte;
  assign CMD_DONE = q.done;
  assign CMD_STATUS = q.status;
  assign VAR_RD_DATA = q.rd_data;
  assign ACCU = q.acc;
  assign XREG = q.xr;
  assign FLAG_ZERO = q.zf;
  assign FLAG_NEG = q.nf;
  assign FLAG_CARRY = q.cf;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  logic go;
  assign go = (q.st == calc_pkg::ST_EXEC) && !ACC_LOAD && !X_LOAD;

  property p_load_var;
    go && q.op == calc_pkg::OP_VAR_ACC && q.typ == calc_pkg::T_LOAD
    |=> q.vars[$past(q.idx)] == $past(q.acc);
  endproperty
  a_load_var: assert property (p_load_var) else $error("var load from accu wrong");

  property p_add_acc;
    go && q.op == calc_pkg::OP_ACC_VAR && q.typ == calc_pkg::T_ADD
    |=> q.acc == $past(q.acc) + $past(q.vars[q.idx]);
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("accu add wrong");

  property p_xor_x;
    go && q.op == calc_pkg::OP_VAR_X && q.typ == calc_pkg::T_XOR
    |=> q.vars[$past(q.idx)] == ($past(q.vars[q.idx]) ^ $past(q.xr)) && $stable(q.xr);
  endproperty
  a_xor_x: assert property (p_xor_x) else $error("var xor X wrong");

  property p_sub_var;
    go && q.op == calc_pkg::OP_VAR_ACC && q.typ == calc_pkg::T_SUB
    |=> q.vars[$past(q.idx)] == $past(q.vars[q.idx]) - $past(q.acc);
  endproperty
  a_sub_var: assert property (p_sub_var) else $error("var subtract wrong");

  property p_not_var;
    go && q.op == calc_pkg::OP_VAR_ACC && q.typ == calc_pkg::T_NOT
    |=> q.vars[$past(q.idx)] == ~$past(q.acc);
  endproperty
  a_not_var: assert property (p_not_var) else $error("invert wrong");

  property p_swap;
    go && q.op == calc_pkg::OP_ACC_VAR && q.typ == calc_pkg::T_SWAP
    |=> q.acc == $past(q.vars[q.idx]) && q.vars[$past(q.idx)] == $past(q.acc);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_comp;
    go && q.op == calc_pkg::OP_ACC_VAR && q.typ == calc_pkg::T_COMP
    |=> $stable(q.acc) && $stable(q.vars) && FLAG_CARRY == ($past(q.acc) < $past(var_v));
  endproperty
  a_comp: assert property (p_comp) else $error("compare altered operands");

  property p_reply;
    go && q.from_link && op_ok && typ_ok
    |=> TX_VALID && TX_DATA == calc_pkg::HOST_ADDR && q.tx_buf[2] == calc_pkg::STATUS_OK;
  endproperty
  a_reply: assert property (p_reply) else $error("reply header wrong");

  property p_bad_sum;
    q.st == calc_pkg::ST_RECV && RX_VALID && q.cnt == calc_pkg::B_LAST && RX_DATA != q.sum
    |=> !TX_VALID [*3];
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum answered");
endmodule

// ===== dv/host_link_model.sv
// Host on the byte link: sends command frames and collects the replies.
// Assumes one clock; every output changes by non-blocking assignment at the rising edge.
module host_link_model (
  input wire logic clk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Flipping one checksum bit is the only fault this host ever makes
  task automatic send(input logic [63:0] hdr, input logic bad);
    logic [7:0] ck;
    ck = 8'h00;
    for (int i = 0; i < 8; i++) ck += hdr[8*i +: 8];
    for (int i = 0; i < 9; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= (i < 8) ? hdr[63-8*i -: 8] : ck ^ {7'h00, bad};
      do @(posedge clk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    // Released line shows the inverse so a stale byte is never mistaken for data
    rx_data <= ~rx_data;
  endtask
  task automatic recv(output logic [71:0] r);
    int n;
    n = 0;
    r = 72'h0;
    while (n < 9)
    begin
      tx_ready <= 1'($urandom_range(1, 0));
      @(posedge clk);
      if (tx_valid && tx_ready)
      begin
        r = {r[63:0], tx_data};
        n++;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// ===== dv/test_user_variable_register_alu.sv
// Self-checking bench: reference model of variables, accumulator, X and flags.
// Assumes the link host model beside it; all inputs change at the rising edge.
module test_user_variable_register_alu;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic CMD_VALID = 1'b0, ACC_LOAD = 1'b0, X_LOAD = 1'b0;
  logic [7:0] CMD_OPCODE = 8'h00, CMD_TYPE = 8'h00, CMD_INDEX = 8'h00, VAR_RD_INDEX = 8'h00;
  logic [31:0] ACC_LOAD_DATA = 32'h0, X_LOAD_DATA = 32'h0;
  logic RX_VALID, RX_READY, TX_VALID, TX_READY, CMD_READY, CMD_DONE;
  logic [7:0] RX_DATA, TX_DATA, CMD_STATUS;
  logic [31:0] VAR_RD_DATA, ACCU, XREG;
  logic FLAG_ZERO, FLAG_NEG, FLAG_CARRY;
  logic [31:0] vars [256] = '{default: 32'h0};
  logic [31:0] acc = 32'h0, x = 32'h0;
  logic fz = 1'b0, fn = 1'b0, fc = 1'b0;
  logic [7:0] st;
  int failures = 0;
  int comparisons = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  user_var_alu user_var_alu_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_DATA(TX_DATA), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OPCODE(CMD_OPCODE),
    .CMD_TYPE(CMD_TYPE), .CMD_INDEX(CMD_INDEX), .CMD_DONE(CMD_DONE), .CMD_STATUS(CMD_STATUS),
    .ACC_LOAD(ACC_LOAD), .ACC_LOAD_DATA(ACC_LOAD_DATA), .X_LOAD(X_LOAD),
    .X_LOAD_DATA(X_LOAD_DATA), .VAR_RD_INDEX(VAR_RD_INDEX), .VAR_RD_DATA(VAR_RD_DATA),
    .ACCU(ACCU), .XREG(XREG), .FLAG_ZERO(FLAG_ZERO), .FLAG_NEG(FLAG_NEG),
    .FLAG_CARRY(FLAG_CARRY));
  host_link_model host_link_model_inst (.clk(SYS_CLK), .rx_valid(RX_VALID),
    .rx_ready(RX_READY), .rx_data(RX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY),
    .tx_data(TX_DATA));
  task automatic summarize();
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] model(input logic [7:0] op, input logic [7:0] t,
    input logic [7:0] i);
    logic [31:0] d, s, r;
    d = (op == calc_pkg::OP_ACC_VAR) ? acc : vars[i];
    s = (op == calc_pkg::OP_VAR_ACC) ? acc : (op == calc_pkg::OP_ACC_VAR) ? vars[i] : x;
    st = calc_pkg::STATUS_OK;
    if (op < calc_pkg::OP_VAR_ACC || op > calc_pkg::OP_VAR_X)
      st = calc_pkg::STATUS_BAD_OP;
    else if (t > calc_pkg::T_COMP)
      st = calc_pkg::STATUS_BAD_TYPE;
    if (st != calc_pkg::STATUS_OK)
      return 32'h0;
    case (t)
      0: r = d + s;
      1: r = d - s;
      2: r = d * s;
      // Zero divisor leaves the destination as it was
      // Cast keeps the quotient signed; an unsigned branch would make it unsigned
      3: r = (s == 0) ? d : 32'($signed(d) / $signed(s));
      4: r = (s == 0) ? d : 32'($signed(d) % $signed(s));
      5: r = d & s;
      6: r = d | s;
      7: r = d ^ s;
      8: r = ~s;
      9: r = s;
      10: r = s;
      default:
      begin
        r = d;
        fz = (d == s);
        fn = ($signed(d) < $signed(s));
        fc = (d < s);
      end
    endcase
    if (op == calc_pkg::OP_ACC_VAR) acc = r; else vars[i] = r;
    if (t == calc_pkg::T_SWAP && op == calc_pkg::OP_VAR_ACC) acc = d;
    if (t == calc_pkg::T_SWAP && op == calc_pkg::OP_ACC_VAR) vars[i] = d;
    if (t == calc_pkg::T_SWAP && op == calc_pkg::OP_VAR_X) x = d;
    return r;
  endfunction
  // A quarter of the accu and X loads are zero to reach the divide guard and equal compares
  task automatic load(input logic [7:0] i);
    ACC_LOAD <= 1'b1;
    X_LOAD <= 1'b1;
    ACC_LOAD_DATA <= ($urandom_range(3, 0) == 0) ? 32'h0 : $urandom;
    X_LOAD_DATA <= ($urandom_range(3, 0) == 0) ? 32'h0 : $urandom;
    VAR_RD_INDEX <= i;
    @(posedge SYS_CLK);
    acc = ACC_LOAD_DATA;
    x = X_LOAD_DATA;
    ACC_LOAD <= 1'b0;
    X_LOAD <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] t, input logic [7:0] i);
    logic [31:0] r;
    load(i);
    CMD_VALID <= 1'b1;
    CMD_OPCODE <= op;
    CMD_TYPE <= t;
    CMD_INDEX <= i;
    do @(posedge SYS_CLK); while (!CMD_READY);
    CMD_VALID <= 1'b0;
    r = model(op, t, i);
    do @(posedge SYS_CLK); while (!CMD_DONE);
    @(posedge SYS_CLK);
    chk({CMD_STATUS, CMD_DONE}, {st, 1'b0});
    chk({ACCU, XREG}, {acc, x});
    chk(VAR_RD_DATA, vars[i]);
    chk({FLAG_ZERO, FLAG_NEG, FLAG_CARRY}, {fz, fn, fc});
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] t, input logic [7:0] i,
    input logic [7:0] tgt, input logic bad);
    logic [71:0] r;
    logic [31:0] v;
    logic [7:0] ck;
    load(i);
    host_link_model_inst.send({tgt, op, t, i, 32'($urandom)}, bad);
    if (bad || tgt != calc_pkg::DEV_ADDR)
    begin
      repeat (3) @(posedge SYS_CLK);
      chk({TX_VALID, ACCU, XREG, VAR_RD_DATA}, {1'b0, acc, x, vars[i]});
      return;
    end
    v = model(op, t, i);
    host_link_model_inst.recv(r);
    ck = calc_pkg::HOST_ADDR + calc_pkg::DEV_ADDR + st + op;
    ck = ck + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    chk(r, {calc_pkg::HOST_ADDR, calc_pkg::DEV_ADDR, st, op, v, ck});
    chk({ACCU, XREG, VAR_RD_DATA}, {acc, x, vars[i]});
  endtask
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h9062));
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    @(posedge SYS_CLK);
    chk({ACCU, XREG, CMD_READY}, {64'h0, 1'b1});
    repeat (2)
      for (int op = 8'h28; op < 8'h2c; op++)
        for (int t = 0; t < 13; t++)
          cmd(8'(op), 8'(t), 8'($urandom_range(3, 0)) * 8'h55);
    for (int t = 0; t < 12; t++)
    begin
      frame(8'h29, 8'(t), 8'hff, calc_pkg::DEV_ADDR, t == 4);
      frame(8'h2a, 8'(t), 8'hff, 8'h05, 1'b0);
      frame(8'($urandom_range(8'h2b, 8'h29)), 8'(t), 8'hff, calc_pkg::DEV_ADDR, 1'b0);
    end
    summarize();
  end
endmodule
